// file: verilog/dl_pkg.sv
// Shared constants and types for the dual input latch front end
`default_nettype none
package dl_pkg;
    // ==========================================================
    // Word format
    localparam int          DL_WORD_W      = 12;
    localparam int          DL_MSB         = 11;
    localparam int          DL_LSB         = 0;
    localparam logic [11:0] DL_CODE_RESET  = 12'h000;
    // ==========================================================
    // Pipeline and timing
    localparam int          DL_FIFO_DEPTH      = 4;
    localparam int          DL_LATENCY_CLKS    = 4;
    localparam int          DL_PRIME_LEVEL     = DL_LATENCY_CLKS - 1;
    localparam int          DL_SYS_CLK_MHZ     = 100;
    localparam int          DL_MAX_UPDATE_MSPS = 200;
    // ==========================================================
    // Mode strap
    localparam logic        DL_STRAP_DUAL_LEVEL = 1'b1;
    localparam logic        DL_DIV_CLK_RESET    = 1'b0;

    typedef logic [DL_MSB:DL_LSB] dl_code_t;

    typedef struct packed {
        dl_code_t chan_a;
        dl_code_t chan_b;
    } dl_code_pair_t;

    typedef struct packed {
        logic write;
        logic clock;
    } dl_strobe_t;

    typedef enum logic {
        DL_MODE_INTERLEAVED,
        DL_MODE_DUAL
    } dl_mode_t;
endpackage
`default_nettype wire

// file: verilog/dl_fifo.sv
// Small word FIFO used as the converter latch pipeline
`default_nettype none
module dl_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 4
) (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       en,
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [WIDTH-1:0]           in_data,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [WIDTH-1:0]                out_data,
    output logic [$clog2(DEPTH+1)-1:0]      level
);
    localparam int PW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH+1);
    localparam logic [LW-1:0] FULL_LEVEL = LW'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR   = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0]    wr_ptr_r;
    logic [PW-1:0]    rd_ptr_r;
    logic [LW-1:0]    level_r;
    logic [WIDTH-1:0] data_r;
    wire  logic       push;
    wire  logic       pop;
    wire  logic [PW-1:0] wr_ptr_nxt;
    wire  logic [PW-1:0] rd_ptr_nxt;

    // ==========================================================
    // Handshakes
    assign in_ready   = (level_r != FULL_LEVEL);
    assign out_valid  = (level_r != '0);
    assign push       = en & in_valid & in_ready;
    assign pop        = en & out_ready & out_valid;
    assign wr_ptr_nxt = (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + 1'b1;
    assign rd_ptr_nxt = (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + 1'b1;
    assign out_data   = data_r;
    assign level      = level_r;

    // ==========================================================
    // Storage, no reset needed on the array
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            level_r  <= '0;
            data_r   <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_nxt;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_nxt;
                data_r   <= mem_r[rd_ptr_r];
            end
            if (push && !pop) begin
                level_r <= level_r + 1'b1;
            end else if (pop && !push) begin
                level_r <= level_r - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// file: verilog/dl_latch_if.sv
// Dual input latch front end with dual-bus and interleaved modes
//
// Functional notes
// - Each port takes a 12-bit offset binary word, bit 11 most significant.
// - Converter latches accept updates up to 200 mega-samples per second; here at most one per two SYS_CLK cycles, 50 at 100 MHz.
// - Strap low selects interleaved single bus; strap high selects dual bus.
// - Dual bus: each channel has own port, write and clock, independent.
// - Interleaved: I and Q words arrive on port A; port B word ignored.
// - Write strobe drives the input latch; update clock drives converter latch.
// - Input latch captures its port word on the write strobe rising edge.
// - Written word reaches the converter output exactly 4 clocks later.
// - Interleaved: select high routes to I latch, low to Q latch.
// - Interleaved: the unselected input latch recirculates and keeps its value.
// - Interleaved: both words pass on at the next falling write edge.
// - Interleaved: shared clock is halved before driving converter latches.
// - Pairing reset high holds the divided converter clock low.
// - Interleaved: port B write is select; port B clock is pairing reset.
`default_nettype none
module dl_latch_if (
    input  wire logic               SYS_CLK,
    input  wire logic               RESET_N,
    input  wire logic               CLK_EN,
    input  wire logic               MODE_STRAP,
    input  wire dl_pkg::dl_code_t   PORT_A_DATA_WORD,
    input  wire dl_pkg::dl_code_t   PORT_B_DATA_WORD,
    input  wire dl_pkg::dl_strobe_t PORT_A_STROBES,
    input  wire dl_pkg::dl_strobe_t PORT_B_STROBES,
    output dl_pkg::dl_code_pair_t   CONVERTER_CODES,
    output logic [1:0]              CONVERTER_UPDATE,
    output logic                    DIVIDED_CONVERTER_LATCH_CLOCK
);
    import dl_pkg::*;

    localparam int LW = $clog2(DL_FIFO_DEPTH+1);
    localparam logic [LW-1:0] PRIME = LW'(DL_PRIME_LEVEL);

    // ==========================================================
    // Declarations
    dl_mode_t   mode_r;
    dl_mode_t   mode_nxt;
    logic       wr_a_prev_r;
    logic       wr_b_prev_r;
    logic       ck_a_prev_r;
    logic       ck_b_prev_r;
    dl_code_t   ilat_a_r;
    dl_code_t   ilat_b_r;
    dl_code_t   ilat_a_nxt;
    dl_code_t   ilat_b_nxt;
    dl_code_t   hold_a_r;
    dl_code_t   hold_b_r;
    logic       div_r;
    logic       div_nxt;
    logic [1:0] upd_r;
    logic       dual;

    wire logic     wr_a_rise;
    wire logic     wr_a_fall;
    wire logic     wr_b_rise;
    wire logic     ck_a_rise;
    wire logic     ck_b_rise;
    wire logic     iq_select;
    wire logic     pair_rst;
    wire logic     settled;
    wire logic     div_rise;
    wire logic     adv_a;
    wire logic     adv_b;
    wire dl_code_t src_a;
    wire dl_code_t src_b;
    wire logic     rdy_a;
    wire logic     rdy_b;
    wire logic     pop_a;
    wire logic     pop_b;
    wire logic     push_a;
    wire logic     push_b;
    wire dl_code_t code_a;
    wire dl_code_t code_b;
    wire logic [LW-1:0] lvl_a;
    wire logic [LW-1:0] lvl_b;

    // ==========================================================
    // Mode strap decode, taken by a clocked register and by the settled compare
    always_comb begin
        case (MODE_STRAP)
            DL_STRAP_DUAL_LEVEL: mode_nxt = DL_MODE_DUAL;
            default:             mode_nxt = DL_MODE_INTERLEAVED;
        endcase
    end

    // Strap is treated as static: a change mid-stream just switches paths
    always_comb begin
        case (mode_r)
            DL_MODE_DUAL: dual = 1'b1;
            default:      dual = 1'b0;
        endcase
    end

    // First cycle after reset still runs the reset mode (dual); with the strap low, a pin held high there is no load
    assign settled = (mode_nxt == mode_r);

    // ==========================================================
    // Edge detection on synchronous strobe pins
    // One sample per system clock, so strobes must stay stable one cycle each
    assign wr_a_rise = PORT_A_STROBES.write & ~wr_a_prev_r;
    assign wr_a_fall = ~PORT_A_STROBES.write & wr_a_prev_r;
    assign wr_b_rise = PORT_B_STROBES.write & ~wr_b_prev_r;
    assign ck_a_rise = PORT_A_STROBES.clock & ~ck_a_prev_r;
    assign ck_b_rise = PORT_B_STROBES.clock & ~ck_b_prev_r;

    // Port B pins change meaning in interleaved mode
    assign iq_select = PORT_B_STROBES.write;
    assign pair_rst  = PORT_B_STROBES.clock;

    // ==========================================================
    // Input latches
    // Interleaved: only the port A word is taken, port B word never enters
    assign ilat_a_nxt = dual ? (wr_a_rise ? PORT_A_DATA_WORD : ilat_a_r)
                      : ((wr_a_rise && iq_select) ? PORT_A_DATA_WORD : ilat_a_r);
    assign ilat_b_nxt = dual ? (wr_b_rise ? PORT_B_DATA_WORD : ilat_b_r)
                      : ((wr_a_rise && !iq_select) ? PORT_A_DATA_WORD : ilat_b_r);

    // ==========================================================
    // Divided converter clock for interleaved mode
    // Held low under pairing reset so the first rise lines up with an I/Q pair
    always_comb begin
        if (dual || pair_rst) begin
            div_nxt = DL_DIV_CLK_RESET;
        end else if (ck_a_rise) begin
            div_nxt = ~div_r;
        end else begin
            div_nxt = div_r;
        end
    end
    assign div_rise = div_nxt & ~div_r;

    // ==========================================================
    // Converter pipeline advance and source select
    assign adv_a  = settled & (dual ? ck_a_rise : div_rise);
    assign adv_b  = settled & (dual ? ck_b_rise : div_rise);
    assign src_a  = dual ? ilat_a_r : hold_a_r;
    assign src_b  = dual ? ilat_b_r : hold_b_r;
    assign push_a = adv_a & rdy_a;
    assign push_b = adv_b & rdy_b;
    // Pipeline runs primed at one word short of the latency
    assign pop_a  = adv_a & (lvl_a == PRIME);
    assign pop_b  = adv_b & (lvl_b == PRIME);

    // ==========================================================
    // State registers, frozen while the clock enable is low
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            mode_r      <= DL_MODE_DUAL;
            wr_a_prev_r <= 1'b0;
            wr_b_prev_r <= 1'b0;
            ck_a_prev_r <= 1'b0;
            ck_b_prev_r <= 1'b0;
            div_r       <= DL_DIV_CLK_RESET;
        end else if (CLK_EN) begin
            mode_r      <= mode_nxt;
            wr_a_prev_r <= PORT_A_STROBES.write;
            wr_b_prev_r <= PORT_B_STROBES.write;
            ck_a_prev_r <= PORT_A_STROBES.clock;
            ck_b_prev_r <= PORT_B_STROBES.clock;
            div_r       <= div_nxt;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ilat_a_r <= DL_CODE_RESET;
            ilat_b_r <= DL_CODE_RESET;
        end else if (CLK_EN && settled) begin
            ilat_a_r <= ilat_a_nxt;
            ilat_b_r <= ilat_b_nxt;
        end
    end

    // Both interleaved words move on together at the falling write edge
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            hold_a_r <= DL_CODE_RESET;
            hold_b_r <= DL_CODE_RESET;
        end else if (CLK_EN && !dual && wr_a_fall) begin
            hold_a_r <= ilat_a_r;
            hold_b_r <= ilat_b_r;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            upd_r <= 2'h0;
        end else if (CLK_EN) begin
            upd_r <= {pop_a, pop_b};
        end
    end

    // ==========================================================
    // Converter latch pipelines; output word stays until the next pop
    dl_fifo #(
        .WIDTH (DL_WORD_W),
        .DEPTH (DL_FIFO_DEPTH)
    ) u_pipe_a (
        .clk       (SYS_CLK),
        .rst_n     (RESET_N),
        .en        (CLK_EN),
        .in_valid  (push_a),
        .in_ready  (rdy_a),
        .in_data   (src_a),
        .out_valid (),
        .out_ready (pop_a),
        .out_data  (code_a),
        .level     (lvl_a)
    );

    dl_fifo #(
        .WIDTH (DL_WORD_W),
        .DEPTH (DL_FIFO_DEPTH)
    ) u_pipe_b (
        .clk       (SYS_CLK),
        .rst_n     (RESET_N),
        .en        (CLK_EN),
        .in_valid  (push_b),
        .in_ready  (rdy_b),
        .in_data   (src_b),
        .out_valid (),
        .out_ready (pop_b),
        .out_data  (code_b),
        .level     (lvl_b)
    );

    // ==========================================================
    // Outputs
    assign CONVERTER_CODES.chan_a         = code_a;
    assign CONVERTER_CODES.chan_b         = code_b;
    assign CONVERTER_UPDATE               = upd_r;
    assign DIVIDED_CONVERTER_LATCH_CLOCK  = div_r;
endmodule
`default_nettype wire

// file: sim/dl_latch_props.sv
// Concurrent checks on the ports of the latch front end
`default_nettype none
module dl_latch_props (
    input wire logic                  SYS_CLK,
    input wire logic                  RESET_N,
    input wire logic                  CLK_EN,
    input wire logic                  MODE_STRAP,
    input wire dl_pkg::dl_code_t      PORT_A_DATA_WORD,
    input wire dl_pkg::dl_code_t      PORT_B_DATA_WORD,
    input wire dl_pkg::dl_strobe_t    PORT_A_STROBES,
    input wire dl_pkg::dl_strobe_t    PORT_B_STROBES,
    input wire dl_pkg::dl_code_pair_t CONVERTER_CODES,
    input wire logic [1:0]            CONVERTER_UPDATE,
    input wire logic                  DIVIDED_CONVERTER_LATCH_CLOCK
);
    timeunit 1ns;
    timeprecision 1ps;
    import dl_pkg::*;
    // ==========================================================
    // Properties
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    property p_pulse;
        CONVERTER_UPDATE[1] |=> !CONVERTER_UPDATE[1];
    endproperty
    a_pulse: assert property (p_pulse) else $error("update pulse too long");
    property p_hold_a;
        !CONVERTER_UPDATE[1] |-> $stable(CONVERTER_CODES.chan_a);
    endproperty
    a_hold_a: assert property (p_hold_a) else $error("code a moved");
    property p_hold_b;
        !CONVERTER_UPDATE[0] |-> $stable(CONVERTER_CODES.chan_b);
    endproperty
    a_hold_b: assert property (p_hold_b) else $error("code b moved");
    // Guarded by one enabled previous cycle, since a frozen pulse may outlive its cause
    property p_dual_a;
        CONVERTER_UPDATE[1] && MODE_STRAP && $past(MODE_STRAP, 2) && $past(CLK_EN)
            |-> $past(PORT_A_STROBES.clock) && !$past(PORT_A_STROBES.clock, 2);
    endproperty
    a_dual_a: assert property (p_dual_a) else $error("a update without clock");
    property p_dual_b;
        CONVERTER_UPDATE[0] && MODE_STRAP && $past(MODE_STRAP, 2) && $past(CLK_EN)
            |-> $past(PORT_B_STROBES.clock) && !$past(PORT_B_STROBES.clock, 2);
    endproperty
    a_dual_b: assert property (p_dual_b) else $error("b update without clock");
    property p_div_dual;
        MODE_STRAP && $past(MODE_STRAP) |-> !DIVIDED_CONVERTER_LATCH_CLOCK;
    endproperty
    a_div_dual: assert property (p_div_dual) else $error("divided clock in dual");
    property p_pair_rst;
        !MODE_STRAP && !$past(MODE_STRAP, 2) && $past(PORT_B_STROBES.clock)
            && $past(PORT_B_STROBES.clock, 2) |-> !DIVIDED_CONVERTER_LATCH_CLOCK;
    endproperty
    a_pair_rst: assert property (p_pair_rst) else $error("divided clock not held");
    property p_div_step;
        $rose(DIVIDED_CONVERTER_LATCH_CLOCK) |-> $past(PORT_A_STROBES.clock);
    endproperty
    a_div_step: assert property (p_div_step) else $error("divided clock rose alone");
    property p_iq_pair;
        !MODE_STRAP && !$past(MODE_STRAP, 2) |-> CONVERTER_UPDATE[1] == CONVERTER_UPDATE[0];
    endproperty
    a_iq_pair: assert property (p_iq_pair) else $error("pair updated apart");
    property p_freeze;
        !CLK_EN |=> $stable(CONVERTER_CODES) && $stable(DIVIDED_CONVERTER_LATCH_CLOCK);
    endproperty
    a_freeze: assert property (p_freeze) else $error("moved while disabled");
    c_dual: cover property (CONVERTER_UPDATE[1] && MODE_STRAP);
    c_iq: cover property (CONVERTER_UPDATE == 2'b11 && !MODE_STRAP);
    c_div: cover property ($rose(DIVIDED_CONVERTER_LATCH_CLOCK));
endmodule
bind dl_latch_if dl_latch_props u_props (
    .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN), .MODE_STRAP(MODE_STRAP),
    .PORT_A_DATA_WORD(PORT_A_DATA_WORD), .PORT_B_DATA_WORD(PORT_B_DATA_WORD),
    .PORT_A_STROBES(PORT_A_STROBES), .PORT_B_STROBES(PORT_B_STROBES),
    .CONVERTER_CODES(CONVERTER_CODES), .CONVERTER_UPDATE(CONVERTER_UPDATE),
    .DIVIDED_CONVERTER_LATCH_CLOCK(DIVIDED_CONVERTER_LATCH_CLOCK)
);
`default_nettype wire

// file: sim/dl_src_model.sv
// Data source model driving words and strobes into the front end
`default_nettype none
module dl_src_model (
    input  wire logic             clk,
    output var dl_pkg::dl_code_t  da,
    output var dl_pkg::dl_code_t  db,
    output var dl_pkg::dl_strobe_t sa,
    output var dl_pkg::dl_strobe_t sb
);
    timeunit 1ns;
    timeprecision 1ps;
    import dl_pkg::*;
    // ==========================================================
    // Port B level kept outside pulses (select and pairing reset)
    dl_strobe_t b_level;
    initial begin
        da = 12'h000;
        db = 12'h000;
        sa = 2'b00;
        sb = 2'b00;
        b_level = 2'b00;
    end
    task automatic set_b(input dl_strobe_t lvl);
        b_level = lvl;
        sb = lvl;
    endtask
    // Clock tied to write keeps the edge order without a 2 ns margin
    task automatic period(input dl_code_t wa, input dl_code_t wb, input dl_strobe_t pa,
                          input dl_strobe_t pb, input int hi);
        @(negedge clk);
        da = wa;
        db = wb;
        sa = pa;
        sb = pb | b_level;
        repeat (hi) @(negedge clk);
        sa = 2'b00;
        sb = b_level;
        da = ~da; // Released lines must not keep the word
        db = ~db;
        repeat (hi - 1) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the dual input latch front end
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dl_pkg::*;
    logic          sys_clk;
    logic          reset_n;
    logic          clk_en;
    logic          mode_strap;
    logic          div_clk;
    logic          div_prev = 1'b0;
    logic [1:0]    upd;
    dl_code_t      da;
    dl_code_t      db;
    dl_strobe_t    sa;
    dl_strobe_t    sb;
    dl_code_pair_t codes;
    int            n_fail = 0;
    int            n_compared = 0;
    int            n_upd_a;
    int            n_upd_b;
    int            n_div;
    dl_code_t      qa[$];
    dl_code_t      qb[$];
    dl_code_pair_t qp[$];
    dl_code_t      tbl[10] = '{12'h800, 12'hfff, 12'h000, 12'h001, 12'h7ff,
                               12'h555, 12'haaa, 12'h123, 12'hc0f, 12'h3f0};
    dl_src_model src (.clk(sys_clk), .da(da), .db(db), .sa(sa), .sb(sb));
    dl_latch_if dut (
        .SYS_CLK(sys_clk), .RESET_N(reset_n), .CLK_EN(clk_en), .MODE_STRAP(mode_strap),
        .PORT_A_DATA_WORD(da), .PORT_B_DATA_WORD(db), .PORT_A_STROBES(sa),
        .PORT_B_STROBES(sb), .CONVERTER_CODES(codes), .CONVERTER_UPDATE(upd),
        .DIVIDED_CONVERTER_LATCH_CLOCK(div_clk)
    );
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (upd[1] === 1'b1) n_upd_a++;
        if (upd[0] === 1'b1) n_upd_b++;
        if (div_clk === 1'b1 && div_prev !== 1'b1) n_div++;
        div_prev <= div_clk;
    end
    // ==========================================================
    // Helpers
    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    task automatic tally_and_finish;
        if (n_fail == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic do_reset(input logic strap, input dl_strobe_t lvl);
        @(negedge sys_clk);
        reset_n = 1'b0;
        mode_strap = strap;
        clk_en = 1'b1;
        src.set_b(lvl);
        repeat (5) @(negedge sys_clk);
        chk(codes === 24'h000000 && upd === 2'b00 && div_clk === 1'b0, "reset");
        reset_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        qa.delete();
        qb.delete();
        qp.delete();
        n_upd_a = 0;
        n_upd_b = 0;
        n_div = 0;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_dual;
        dl_code_t   ea;
        dl_code_t   eb;
        dl_strobe_t pb;
        do_reset(1'b1, 2'b00);
        for (int r = 0; r < 10; r++) begin
            pb = (r % 2) ? 2'b11 : 2'b00;
            src.period(tbl[r], ~tbl[9-r], 2'b11, pb, (r < 5) ? 2 : 3);
            qa.push_back(tbl[r]);
            if (pb.write) qb.push_back(~tbl[9-r]);
            ea = (qa.size() > 4) ? qa[qa.size()-5] : 12'h000;
            eb = (qb.size() > 4) ? qb[qb.size()-5] : 12'h000;
            chk(codes.chan_a === ea, "dual a code");
            chk(codes.chan_b === eb, "dual b code");
        end
        chk(n_upd_a == 7 && n_upd_b == 2, "dual pulse count");
    endtask
    task automatic t_freeze;
        dl_code_pair_t c;
        c = codes;
        clk_en = 1'b0;
        src.period(12'h5a5, 12'h5a5, 2'b11, 2'b11, 2);
        clk_en = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk(codes === c && n_upd_a == 7, "edges seen while frozen");
    endtask
    task automatic t_iq;
        dl_code_pair_t e;
        do_reset(1'b0, 2'b01);
        src.period(12'h000, 12'hbad, 2'b11, 2'b00, 2);
        chk(div_clk === 1'b0 && n_div == 0, "pairing reset");
        src.set_b(2'b00);
        @(negedge sys_clk);
        for (int k = 0; k < 6; k++) begin
            src.set_b(2'b10);
            src.period(tbl[k], tbl[k+4], 2'b11, 2'b00, 2);
            repeat (2) @(negedge sys_clk);
            e = (qp.size() > 3) ? qp[qp.size()-4] : 24'h000000;
            chk(codes === e, "interleaved pair");
            src.set_b(2'b00);
            src.period(tbl[9-k], tbl[k], 2'b11, 2'b00, 2);
            repeat (2) @(negedge sys_clk);
            qp.push_back({tbl[k], tbl[9-k]});
        end
        chk(n_div == 6 && n_upd_a == 3 && n_upd_b == 3, "divided rate");
    endtask
    initial begin
        reset_n = 1'b0;
        clk_en = 1'b0;
        mode_strap = 1'b1;
        t_dual;
        t_freeze;
        t_iq;
        tally_and_finish;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
